/* wsc_wake_regs.sv */
// Wake-source control register bank with wake gating, bias decode and interrupt scope
`timescale 1ns/10ps
`default_nettype none

module wsc_wake_regs (
	// Clock, reset, enable
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst,
	input  wire logic                  i_ce,
	// Serial frame port: write applied at end of frame, read selected by address
	input  wire wsc_pkg::wsc_frame_s   i_frame,
	input  wire logic [6:0]            i_rd_addr,
	output logic [7:0]                 o_rd_data,
	// Device mode events and levels
	input  wire logic                  i_soft_reset,
	input  wire logic                  i_restart_entry,
	input  wire logic                  i_failsafe_entry,
	input  wire logic                  i_normal_mode,
	// Device updates of the stop-mode watchdog bit
	input  wire logic                  i_stop_watchdog_off_set,
	input  wire logic                  i_stop_watchdog_off_clr,
	// Wake pins and timer ticks
	input  wire logic                  i_wake_input_a,
	input  wire logic                  i_wake_input_b,
	input  wire logic                  i_wake_input_c,
	input  wire logic                  i_timer_a_tick,
	input  wire logic                  i_timer_b_tick,
	// Other status information events
	input  wire logic                  i_status_event,
	// Wake and interrupt outputs
	output logic                       o_wake_event,
	output logic                       o_int_request,
	output logic [2:0]                 o_input_level_status,
	// Configuration outputs to the analog front end
	output logic                       o_input_a_wake_active,
	output logic                       o_input_b_wake_active,
	output logic                       o_input_c_wake_active,
	output logic                       o_timer_a_wake_active,
	output logic                       o_timer_b_wake_active,
	output logic                       o_measure_active,
	output logic                       o_stop_watchdog_off_hi,
	output wsc_pkg::wsc_bias_ctl_s     o_input_a_bias,
	output wsc_pkg::wsc_bias_ctl_s     o_input_b_bias,
	output wsc_pkg::wsc_bias_ctl_s     o_input_c_bias,
	// Fail-safe request for the bus control register
	output logic                       o_bus_force_wake,
	output wsc_pkg::wsc_bus_mode_e     o_bus_force_mode
);

	// Whole state of the bank except the pin synchronisers
	typedef struct packed {
		logic [7:0]    internal_wake_control;
		logic [7:0]    external_wake_control;
		logic [7:0]    wake_input_bias_control;
		logic [7:0]    rd_data;
		logic          wake_event;
		logic          int_request;
		logic          bus_force_wake;
		logic [2:0]    in_wake_active;
		logic          timer_a_wake_active;
		logic          timer_b_wake_active;
		logic          measure_active;
		wsc_pkg::wsc_bias_ctl_s [2:0] bias;
	} wsc_state_s;

	wsc_state_s st;
	wsc_state_s next_st;

	// Settled pin levels and change pulses, bit 0 is input A
	logic [2:0] pin_level;
	logic [2:0] pin_change;
	logic [2:0] pins;

	// Pins gathered into a vector so the loop can index them
	assign pins = {i_wake_input_c, i_wake_input_b, i_wake_input_a};

	// One synchroniser per wake pin; the pins are asynchronous to the core clock
	// Trade-off: four cycles of latency buy immunity to metastability
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_pin
			wsc_pin_sync u_sync (
				.i_core_clk (i_core_clk),
				.i_rst      (i_rst),
				.i_ce       (i_ce),
				.i_pin      (pins[g]),
				.o_level    (pin_level[g]),
				.o_change   (pin_change[g])
			);
		end
	endgenerate

	// Decode one bias field into resistor controls
	// Every code selects at most one control, so the resistors never fight
	function automatic wsc_pkg::wsc_bias_ctl_s bias_decode(input logic [1:0] code);
		wsc_pkg::wsc_bias_ctl_s r;
		r = '0;
		unique case (wsc_pkg::wsc_bias_e'(code))
			wsc_pkg::BIAS_NONE: r = '0;
			wsc_pkg::BIAS_DOWN: r.pull_down = 1'b1;
			wsc_pkg::BIAS_UP:   r.pull_up = 1'b1;
			wsc_pkg::BIAS_AUTO: r.auto_switch = 1'b1;
		endcase
		return r;
	endfunction

	// Next-state logic
	// Locals hold the register values being built this cycle
	always_comb begin
		logic [7:0] iw;
		logic [7:0] ew;
		logic [7:0] bw;
		logic       meas;
		logic [2:0] en;
		logic       wake;
		iw      = st.internal_wake_control;
		ew      = st.external_wake_control;
		bw      = st.wake_input_bias_control;
		meas    = 1'b0;
		en      = '0;
		wake    = 1'b0;
		next_st = st;
		next_st.bus_force_wake = 1'b0;

		// Later blocks override earlier ones, which sets the event priority
		// Host write lands only when the frame completes; reserved bits are masked off
		if (i_frame.valid) begin
			unique case (i_frame.addr)
				wsc_pkg::ADDR_INTERNAL_WAKE_CONTROL:   iw = i_frame.wdata & wsc_pkg::WMASK_INTERNAL;
				wsc_pkg::ADDR_EXTERNAL_WAKE_CONTROL:   ew = i_frame.wdata & wsc_pkg::WMASK_EXTERNAL;
				wsc_pkg::ADDR_WAKE_INPUT_BIAS_CONTROL: bw = i_frame.wdata & wsc_pkg::WMASK_BIAS;
				default: ;
			endcase
		end

		// The device owns this bit as well as the host
		// Device update of the watchdog bit; set wins over clear and over a host write
		if (i_stop_watchdog_off_clr) begin
			iw[wsc_pkg::POS_STOP_WATCHDOG_OFF_HI] = 1'b0;
		end
		if (i_stop_watchdog_off_set) begin
			iw[wsc_pkg::POS_STOP_WATCHDOG_OFF_HI] = 1'b1;
		end

		// Restart keeps the marked bits and clears the rest
		// Internal register is left as it was on restart
		if (i_restart_entry) begin
			ew = st.external_wake_control & wsc_pkg::RESTART_KEEP_EXTERNAL;
			bw = st.wake_input_bias_control & wsc_pkg::RESTART_KEEP_BIAS;
		end

		// Fail-safe sets every external wake enable bit; a kept measure select still masks A and B
		// The bus control register lives elsewhere; only the request leaves here
		if (i_failsafe_entry) begin
			ew = (st.external_wake_control & wsc_pkg::FAILSAFE_KEEP_EXTERNAL)
				| wsc_pkg::FAILSAFE_SET_EXTERNAL;
			next_st.bus_force_wake = 1'b1;
		end

		// Soft reset overrides every other write to the three registers
		// Same values as power-on, taken as a clocked event
		if (i_soft_reset) begin
			iw = wsc_pkg::RST_INTERNAL_WAKE_CONTROL;
			ew = wsc_pkg::RST_EXTERNAL_WAKE_CONTROL;
			bw = wsc_pkg::RST_WAKE_INPUT_BIAS_CONTROL;
		end

		// Reserved bits are held at zero whatever path wrote the register
		next_st.internal_wake_control   = iw & wsc_pkg::WMASK_INTERNAL;
		next_st.external_wake_control   = ew & wsc_pkg::WMASK_EXTERNAL;
		next_st.wake_input_bias_control = bw & wsc_pkg::WMASK_BIAS;

		// Effective enables come from the current register, so a write acts next cycle
		// Measure select masks A and B without altering their stored enables
		meas  = st.external_wake_control[wsc_pkg::POS_MEASURE_SELECT];
		en[0] = st.external_wake_control[wsc_pkg::POS_INPUT_A_WAKE_ENABLE] & ~meas;
		en[1] = st.external_wake_control[wsc_pkg::POS_INPUT_B_WAKE_ENABLE] & ~meas;
		en[2] = st.external_wake_control[wsc_pkg::POS_INPUT_C_WAKE_ENABLE];
		next_st.in_wake_active      = en;
		next_st.timer_a_wake_active = st.internal_wake_control[wsc_pkg::POS_TIMER_A_WAKE_ENABLE];
		next_st.timer_b_wake_active = st.internal_wake_control[wsc_pkg::POS_TIMER_B_WAKE_ENABLE];
		next_st.measure_active      = meas & i_normal_mode;

		// Wake event from a settled pin change or a timer tick on an enabled source
		// Both directions of a settled pin change count as a wake
		wake = |(pin_change & en)
			| (i_timer_a_tick & st.internal_wake_control[wsc_pkg::POS_TIMER_A_WAKE_ENABLE])
			| (i_timer_b_tick & st.internal_wake_control[wsc_pkg::POS_TIMER_B_WAKE_ENABLE]);
		next_st.wake_event = wake;

		// Interrupt scope: wake only, or every status event as well
		// Status events never raise the wake output itself
		next_st.int_request = wake
			| (i_status_event & st.external_wake_control[wsc_pkg::POS_INTERRUPT_SCOPE]);

		// Bias decode per input
		// Resistor controls follow the register one cycle later
		next_st.bias[0] = bias_decode(st.wake_input_bias_control[wsc_pkg::POS_INPUT_A_BIAS +: 2]);
		next_st.bias[1] = bias_decode(st.wake_input_bias_control[wsc_pkg::POS_INPUT_B_BIAS +: 2]);
		next_st.bias[2] = bias_decode(st.wake_input_bias_control[wsc_pkg::POS_INPUT_C_BIAS +: 2]);

		// Registered read; unmapped addresses return zero
		// Read data lags the address by one enabled edge
		unique case (i_rd_addr)
			wsc_pkg::ADDR_INTERNAL_WAKE_CONTROL:   next_st.rd_data = st.internal_wake_control;
			wsc_pkg::ADDR_EXTERNAL_WAKE_CONTROL:   next_st.rd_data = st.external_wake_control;
			wsc_pkg::ADDR_WAKE_INPUT_BIAS_CONTROL: next_st.rd_data = st.wake_input_bias_control;
			default:                               next_st.rd_data = 8'h00;
		endcase
	end

	// State register; power-on values come from the package
	// Clock enable low freezes every field; reset acts regardless
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st                            <= '0;
			st.internal_wake_control      <= wsc_pkg::RST_INTERNAL_WAKE_CONTROL;
			st.external_wake_control      <= wsc_pkg::RST_EXTERNAL_WAKE_CONTROL;
			st.wake_input_bias_control    <= wsc_pkg::RST_WAKE_INPUT_BIAS_CONTROL;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	// Outputs, all from flip-flops except the constant bus force mode
	// Registered so the analog side never sees a decode glitch
	assign o_rd_data              = st.rd_data;
	assign o_wake_event           = st.wake_event;
	assign o_int_request          = st.int_request;
	// Level status is raw; software discards A and B while measuring
	assign o_input_level_status   = pin_level;
	assign o_input_a_wake_active  = st.in_wake_active[0];
	assign o_input_b_wake_active  = st.in_wake_active[1];
	assign o_input_c_wake_active  = st.in_wake_active[2];
	assign o_timer_a_wake_active  = st.timer_a_wake_active;
	assign o_timer_b_wake_active  = st.timer_b_wake_active;
	assign o_measure_active       = st.measure_active;
	assign o_stop_watchdog_off_hi = st.internal_wake_control[wsc_pkg::POS_STOP_WATCHDOG_OFF_HI];
	assign o_input_a_bias         = st.bias[0];
	assign o_input_b_bias         = st.bias[1];
	assign o_input_c_bias         = st.bias[2];
	assign o_bus_force_wake       = st.bus_force_wake;
	// Bus register owner loads this mode into its field when forced
	// Only wake-capable is ever requested, whatever the bus mode was
	assign o_bus_force_mode       = wsc_pkg::BUS_MODE_WAKE;

endmodule
`default_nettype wire

/* wsc_pkg.sv */
// Package of constants and carriers for the wake-source control register bank
package wsc_pkg;

	// Register addresses on the serial frame port
	localparam logic [6:0] ADDR_INTERNAL_WAKE_CONTROL   = 7'h06;
	localparam logic [6:0] ADDR_EXTERNAL_WAKE_CONTROL   = 7'h07;
	localparam logic [6:0] ADDR_WAKE_INPUT_BIAS_CONTROL = 7'h08;

	// Power-on / soft reset values
	localparam logic [7:0] RST_INTERNAL_WAKE_CONTROL   = 8'h00;
	localparam logic [7:0] RST_EXTERNAL_WAKE_CONTROL   = 8'h07;
	localparam logic [7:0] RST_WAKE_INPUT_BIAS_CONTROL = 8'h00;

	// Writable bit masks; every other bit is reserved and reads zero
	localparam logic [7:0] WMASK_INTERNAL = 8'hc4;
	localparam logic [7:0] WMASK_EXTERNAL = 8'ha7;
	localparam logic [7:0] WMASK_BIAS     = 8'h3f;

	// Restart: bits kept, the rest cleared to zero
	localparam logic [7:0] RESTART_KEEP_EXTERNAL = 8'ha7;
	localparam logic [7:0] RESTART_KEEP_BIAS     = 8'h3f;

	// Fail-safe entry: kept bits and forced ones
	localparam logic [7:0] FAILSAFE_KEEP_EXTERNAL = 8'ha0;
	localparam logic [7:0] FAILSAFE_SET_EXTERNAL  = 8'h07;

	// Internal wake control field positions
	localparam int POS_TIMER_B_WAKE_ENABLE = 7;
	localparam int POS_TIMER_A_WAKE_ENABLE = 6;
	localparam int POS_STOP_WATCHDOG_OFF_HI = 2;

	// External wake control field positions
	localparam int POS_INTERRUPT_SCOPE     = 7;
	localparam int POS_MEASURE_SELECT      = 5;
	localparam int POS_INPUT_C_WAKE_ENABLE = 2;
	localparam int POS_INPUT_B_WAKE_ENABLE = 1;
	localparam int POS_INPUT_A_WAKE_ENABLE = 0;

	// Bias field positions (low bit of each 2-bit field)
	localparam int POS_INPUT_C_BIAS = 4;
	localparam int POS_INPUT_B_BIAS = 2;
	localparam int POS_INPUT_A_BIAS = 0;

	// Bias codes
	typedef enum logic [1:0] {
		BIAS_NONE = 2'b00,
		BIAS_DOWN = 2'b01,
		BIAS_UP   = 2'b10,
		BIAS_AUTO = 2'b11
	} wsc_bias_e;

	// Bus transceiver mode codes
	typedef enum logic [1:0] {
		BUS_MODE_OFF     = 2'b00,
		BUS_MODE_WAKE    = 2'b01,
		BUS_MODE_RX_ONLY = 2'b10,
		BUS_MODE_NORMAL  = 2'b11
	} wsc_bus_mode_e;

	// Completed serial write frame
	typedef struct packed {
		logic       valid;
		logic [6:0] addr;
		logic [7:0] wdata;
	} wsc_frame_s;

	// Bias resistor controls for one wake input
	typedef struct packed {
		logic pull_up;
		logic pull_down;
		logic auto_switch;
	} wsc_bias_ctl_s;

endpackage

/* wsc_pin_sync.sv */
// Three-stage synchroniser with agreement check and change pulse for one wake pin
`timescale 1ns/10ps
`default_nettype none

module wsc_pin_sync (
	// Clock, reset, enable
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	// Asynchronous pin
	input  wire logic i_pin,
	// Settled level and change pulse
	output logic      o_level,
	output logic      o_change
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic change;
	} wsc_sync_s;

	wsc_sync_s st;
	wsc_sync_s next_st;

	// Level only moves once stages two and three agree; stage one feeds stage two only
	always_comb begin
		next_st        = st;
		next_st.s1     = i_pin;
		next_st.s2     = st.s1;
		next_st.s3     = st.s2;
		next_st.change = 1'b0;
		if ((st.s2 == st.s3) && (st.s3 != st.level)) begin
			next_st.level  = st.s3;
			next_st.change = 1'b1;
		end
	end

	// Clock enable freezes the chain
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st <= '0;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	assign o_level  = st.level;
	assign o_change = st.change;

endmodule
`default_nettype wire

/* wsc_wake_regs_sva.sv */
// Port checker for the wake-source control bank
`timescale 1ns/10ps
`default_nettype none

module wsc_wake_regs_sva (
	// Clock, reset, enable
	input wire logic                   i_core_clk,
	input wire logic                   i_rst,
	input wire logic                   i_ce,
	// Read port and events
	input wire logic [6:0]             i_rd_addr,
	input wire logic [7:0]             o_rd_data,
	input wire logic                   i_soft_reset,
	input wire logic                   i_failsafe_entry,
	input wire logic                   i_normal_mode,
	input wire logic                   i_stop_watchdog_off_set,
	input wire logic                   i_stop_watchdog_off_clr,
	input wire logic                   i_timer_a_tick,
	// Observed outputs
	input wire logic                   o_wake_event,
	input wire logic                   o_int_request,
	input wire logic                   o_input_a_wake_active,
	input wire logic                   o_input_b_wake_active,
	input wire logic                   o_input_c_wake_active,
	input wire logic                   o_timer_a_wake_active,
	input wire logic                   o_measure_active,
	input wire logic                   o_stop_watchdog_off_hi,
	input wire logic                   o_bus_force_wake,
	input wire wsc_pkg::wsc_bus_mode_e o_bus_force_mode
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	// Writable bits per address; unmapped reads must be all zero
	function automatic logic [7:0] rmask(input logic [6:0] a);
		if (a == wsc_pkg::ADDR_INTERNAL_WAKE_CONTROL) return wsc_pkg::WMASK_INTERNAL;
		if (a == wsc_pkg::ADDR_EXTERNAL_WAKE_CONTROL) return wsc_pkg::WMASK_EXTERNAL;
		if (a == wsc_pkg::ADDR_WAKE_INPUT_BIAS_CONTROL) return wsc_pkg::WMASK_BIAS;
		return 8'h00;
	endfunction

	property p_rd_reserved;
		i_ce |=> (o_rd_data & ~rmask($past(i_rd_addr))) == 8'h00;
	endproperty
	a_rd_reserved: assert property (p_rd_reserved) else $error("reserved read bit set");

	property p_wake_int;
		o_wake_event |-> o_int_request;
	endproperty
	a_wake_int: assert property (p_wake_int) else $error("wake without interrupt");

	// Active flag one edge later shows the enable that gated the tick
	property p_timer_a;
		i_ce && i_timer_a_tick ##1 o_timer_a_wake_active |-> o_wake_event;
	endproperty
	a_timer_a: assert property (p_timer_a) else $error("timer tick lost");

	property p_measure;
		o_measure_active |-> !o_input_a_wake_active && !o_input_b_wake_active;
	endproperty
	a_measure: assert property (p_measure) else $error("input wake in measure");

	property p_meas_normal;
		o_measure_active && $past(i_ce) |-> $past(i_normal_mode);
	endproperty
	a_meas_normal: assert property (p_meas_normal) else $error("measure outside normal");

	property p_fs_pulse;
		i_ce && i_failsafe_entry && !i_soft_reset |=> o_bus_force_wake && o_bus_force_mode == wsc_pkg::BUS_MODE_WAKE;
	endproperty
	a_fs_pulse: assert property (p_fs_pulse) else $error("no bus force pulse");

	property p_fs_wake;
		i_ce && i_failsafe_entry && !i_soft_reset ##1 i_ce |=> o_input_c_wake_active;
	endproperty
	a_fs_wake: assert property (p_fs_wake) else $error("fail-safe left input c off");

	property p_soft;
		i_ce && i_soft_reset ##1 i_ce |=> o_input_a_wake_active && o_input_c_wake_active && !o_timer_a_wake_active;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset enables wrong");

	property p_wd_set;
		i_ce && i_stop_watchdog_off_set && !i_soft_reset |=> o_stop_watchdog_off_hi;
	endproperty
	a_wd_set: assert property (p_wd_set) else $error("watchdog bit not set");

	property p_wd_clr;
		i_ce && i_stop_watchdog_off_clr && !i_stop_watchdog_off_set |=> !o_stop_watchdog_off_hi;
	endproperty
	a_wd_clr: assert property (p_wd_clr) else $error("watchdog bit not cleared");
endmodule

bind wsc_wake_regs wsc_wake_regs_sva i_wsc_wake_regs_sva (.i_core_clk, .i_rst, .i_ce, .i_rd_addr, .o_rd_data,
	.i_soft_reset, .i_failsafe_entry, .i_normal_mode, .i_stop_watchdog_off_set, .i_stop_watchdog_off_clr,
	.i_timer_a_tick, .o_wake_event, .o_int_request, .o_input_a_wake_active, .o_input_b_wake_active,
	.o_input_c_wake_active, .o_timer_a_wake_active, .o_measure_active, .o_stop_watchdog_off_hi,
	.o_bus_force_wake, .o_bus_force_mode);

`default_nettype wire

/* wsc_host_model.sv */
// Host model issuing write frames and register reads
`timescale 1ns/10ps
`default_nettype none

module wsc_host_model (
	// Clock
	input  wire logic          i_core_clk,
	// Frame and read port toward the bank
	output var wsc_pkg::wsc_frame_s o_frame,
	output var logic [6:0]     o_rd_addr,
	input  wire logic [7:0]    i_rd_data
);
	// Idle port before the first frame
	initial begin
		o_frame = '0;
		o_rd_addr = 7'h00;
	end

	// One whole frame per byte; stale bytes inverted so they never look valid
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		o_frame <= '{valid: 1'b1, addr: a, wdata: d};
		@(posedge i_core_clk);
		o_frame <= '{valid: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// Address held two edges since read data is registered
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		o_rd_addr <= a;
		repeat (2) @(posedge i_core_clk);
		#1 d = i_rd_data;
	endtask
endmodule

`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the wake-source control bank
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	localparam logic [6:0] AI = wsc_pkg::ADDR_INTERNAL_WAKE_CONTROL;
	localparam logic [6:0] AE = wsc_pkg::ADDR_EXTERNAL_WAKE_CONTROL;
	localparam logic [6:0] AB = wsc_pkg::ADDR_WAKE_INPUT_BIAS_CONTROL;
	logic                   clk, rst, ce, nrm, wake, irq, fw, aa, ba, ca, taa, tba, ma, wdo;
	logic [7:0]             ev, rdata, v;
	logic [2:0]             pin, lvl;
	logic [6:0]             raddr;
	wsc_pkg::wsc_frame_s    frame;
	wsc_pkg::wsc_bias_ctl_s bia, bib, bic;
	wsc_pkg::wsc_bus_mode_e fmode;
	int                     n_mismatch, check_count;

	// Event pulses: soft, restart, failsafe, wd set, wd clr, tick a, tick b, status
	wsc_wake_regs i_wsc_wake_regs (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_frame(frame),
		.i_rd_addr(raddr), .o_rd_data(rdata), .i_soft_reset(ev[0]), .i_restart_entry(ev[1]),
		.i_failsafe_entry(ev[2]), .i_normal_mode(nrm), .i_stop_watchdog_off_set(ev[3]),
		.i_stop_watchdog_off_clr(ev[4]), .i_wake_input_a(pin[0]), .i_wake_input_b(pin[1]),
		.i_wake_input_c(pin[2]), .i_timer_a_tick(ev[5]), .i_timer_b_tick(ev[6]), .i_status_event(ev[7]),
		.o_wake_event(wake), .o_int_request(irq), .o_input_level_status(lvl), .o_input_a_wake_active(aa),
		.o_input_b_wake_active(ba), .o_input_c_wake_active(ca), .o_timer_a_wake_active(taa),
		.o_timer_b_wake_active(tba), .o_measure_active(ma), .o_stop_watchdog_off_hi(wdo),
		.o_input_a_bias(bia), .o_input_b_bias(bib), .o_input_c_bias(bic), .o_bus_force_wake(fw),
		.o_bus_force_mode(fmode));
	wsc_host_model i_wsc_host_model (.i_core_clk(clk), .o_frame(frame), .o_rd_addr(raddr), .i_rd_data(rdata));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_wsc_host_model.wr(a, d);
	endtask
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		i_wsc_host_model.rd(a, v);
		chk("rd_data", 16'(e), 16'(v));
	endtask
	// One-cycle event; returns where its registered answer is visible
	task automatic pulse(input logic [7:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 8'h00;
		#1;
	endtask
	// Toggle one pin and watch long enough for the synchroniser
	task automatic pin_wake(input int b, input logic e);
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		pin[b] <= ~pin[b];
		repeat (10) begin
			@(posedge clk);
			#1 seen |= wake;
		end
		chk("pin_wake", 16'(e), 16'(seen));
	endtask

	task automatic t_mask;
		wr(AI, 8'hff);
		wr(AE, 8'hff);
		wr(AB, 8'hff);
		wr(7'h09, 8'hff);
		rchk(AI, 8'hc4);
		rchk(AE, 8'ha7);
		rchk(AB, 8'h3f);
		rchk(7'h09, 8'h00);
		chk("enables", 16'h39, 16'({taa, tba, ma, aa, ba, ca}));
		@(posedge clk);
		nrm <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("measure", 16'h0, 16'(ma));
		@(posedge clk);
		nrm <= 1'b1;
	endtask
	task automatic t_irq;
		wr(AE, 8'h00);
		wr(AI, 8'h40);
		pulse(8'h20);
		chk("wake_irq", 16'h3, 16'({wake, irq}));
		pulse(8'h40);
		chk("wake_irq", 16'h0, 16'({wake, irq}));
		pulse(8'h80);
		chk("wake_irq", 16'h0, 16'({wake, irq}));
		wr(AI, 8'h80);
		pulse(8'h40);
		chk("wake_irq", 16'h3, 16'({wake, irq}));
		wr(AE, 8'h80);
		pulse(8'h80);
		chk("wake_irq", 16'h1, 16'({wake, irq}));
		// Clock enable low must swallow an enabled tick
		@(posedge clk);
		ce <= 1'b0;
		pulse(8'h40);
		chk("frozen", 16'h0, 16'({wake, irq}));
		@(posedge clk);
		ce <= 1'b1;
	endtask
	// Level status of inputs a and b is never judged while measuring
	task automatic t_pin;
		wr(AE, 8'h01);
		pin_wake(0, 1'b1);
		pin_wake(2, 1'b0);
		wr(AE, 8'h23);
		pin_wake(0, 1'b0);
		wr(AE, 8'h06);
		pin_wake(1, 1'b1);
		pin_wake(2, 1'b1);
		chk("level", 16'h2, 16'(lvl));
	endtask
	task automatic t_bias;
		logic [2:0] dec [4];
		dec = '{3'b000, 3'b010, 3'b100, 3'b001};
		for (int c = 0; c < 4; c++) begin
			wr(AB, {2'b11, {3{2'(c)}}});
			rchk(AB, {2'b00, {3{2'(c)}}});
			chk("bias", 16'({3{dec[c]}}), 16'({bia, bib, bic}));
		end
	endtask
	task automatic t_events;
		wr(AE, 8'hff);
		pulse(8'h02);
		rchk(AE, 8'ha7);
		rchk(AB, 8'h3f);
		wr(AE, 8'ha0);
		pulse(8'h04);
		chk("force", 16'h5, 16'({fw, fmode}));
		@(posedge clk);
		#1 chk("force_end", 16'h0, 16'(fw));
		rchk(AE, 8'ha7);
		wr(AI, 8'h00);
		pulse(8'h08);
		chk("wd_set", 16'h1, 16'(wdo));
		pulse(8'h18);
		rchk(AI, 8'h04);
		pulse(8'h10);
		chk("wd_clr", 16'h0, 16'(wdo));
		wr(AI, 8'hff);
		pulse(8'h01);
		rchk(AI, 8'h00);
		rchk(AE, 8'h07);
		rchk(AB, 8'h00);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence after a three-cycle reset
	initial begin
		rst = 1'b1;
		ev = 8'h00;
		pin = 3'h0;
		nrm = 1'b1;
		ce = 1'b1;
		n_mismatch = 0;
		check_count = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rchk(AE, 8'h07);
		t_mask;
		t_irq;
		t_pin;
		t_bias;
		t_events;
		print_verdict;
	end

	// Whole run needs well under 1000 cycles; 10000 means a hang
	initial begin
		#40000;
		n_mismatch++;
		print_verdict;
	end
endmodule

`default_nettype wire
